// >>> buck4_voltage_regs.sv
// buck4 operating-point, alternate-voltage and limit registers
`timescale 1ns/1ps
`default_nettype none
//////////////////////////////////////////////////////////////////////////////
// Contract
// - alternate-voltage register at 0x0E and limit register at 0x0F, 8 bits.
// - power-on reset reloads both registers, factory defaults for marked fields.
// - alternate bit 7 enables buck4, unless forced-off mode holds it off.
// - alternate bits 5..0 hold voltage code, read through the range field.
// - limit bits 7..6 select range: base voltage and step size.
// - written codes above the maximum code are stored as the maximum code.
// - maximum code other than 0x3F/0x00 locks range and maximum until reload.
// - range 00 maps codes 0.5 V to 1.2875 V in 12.5 mV.
// - range 01 maps codes 0.7 V to 1.4875 V in 12.5 mV.
// - range 10 maps codes 0.5 V to 2.075 V in 25 mV.
module buck4_voltage_regs (
  input wire logic mclk_i,                          // system clock
  input wire logic rst_n_i,                         // power-on reset, low
  input wire logic otp_reload_i,                    // reload factory defaults
  input wire buck4_pkg::otp_defaults_t otp_i,       // factory defaults
  input wire buck4_pkg::reg_req_t req_i,            // host register access
  input wire logic forced_off_i,                    // forced-off mode active
  output logic [7:0] rdata_o,                       // read data, registered
  output logic rvalid_o,                            // read data valid pulse
  output buck4_pkg::converter_ctrl_t ctrl_o,        // converter controls
  output logic limit_locked_o,                      // range/max locked
  output logic [21:0] target_uv_o                   // active target voltage
);
  import buck4_pkg::*;

  //////////////////////////////////////////////////////////////////////////
  // register state
  logic enable, next_enable;
  logic power_save, next_power_save;
  logic alt_select, next_alt_select;
  logic [5:0] op_code, next_op_code;
  logic [5:0] alt_code, next_alt_code;
  logic [1:0] range, next_range;
  logic [5:0] max_code, next_max_code;
  logic loaded, next_loaded;
  logic [7:0] next_rdata;
  logic next_rvalid;
  converter_ctrl_t next_ctrl;
  logic next_locked;
  logic locked;
  logic [5:0] wr_code;
  logic [5:0] active_code;

  // lock follows the currently held maximum code
  assign locked = (max_code != CODE_ALL_ONES) && (max_code != CODE_ZERO);
  // clamp is applied against the maximum at the moment of the write
  assign wr_code = (req_i.wdata[CODE_MSB:0] > max_code) ?
                   max_code : req_i.wdata[CODE_MSB:0];
  assign active_code = alt_select ? alt_code : op_code;

  //////////////////////////////////////////////////////////////////////////
  // the decode and read path assume the fixed 8-bit field layout;
  // refuse a package edit that would move a field off the byte
  if (ENABLE_BIT != 7 || POWER_SAVE_BIT != 6 || CODE_MSB != 5 ||
      RANGE_LSB != CODE_MSB + 1)
  begin : g_layout_check
    $error("buck4 register field layout does not fit one byte");
  end

  //////////////////////////////////////////////////////////////////////////
  // next-state of the register fields
  always_comb
  begin
    next_enable = enable;
    next_power_save = power_save;
    next_alt_select = alt_select;
    next_op_code = op_code;
    next_alt_code = alt_code;
    next_range = range;
    next_max_code = max_code;
    next_loaded = 1'b1;
    if (!loaded || otp_reload_i)
    begin
      // factory defaults taken one edge after release, never under reset
      next_enable = otp_i.enable;
      next_op_code = otp_i.op_code;
      next_alt_code = otp_i.alt_code;
      next_range = otp_i.range;
      next_max_code = otp_i.max_code;
      next_power_save = POWER_SAVE_RESET;
      next_alt_select = ALT_SELECT_RESET;
    end
    else if (req_i.wr)
    begin
      case (req_i.addr)
        ADDR_OPERATING_POINT:
        begin
          next_alt_select = req_i.wdata[ALT_SELECT_BIT];
          next_op_code = wr_code;
        end
        ADDR_ALT_VOLTAGE:
        begin
          next_enable = req_i.wdata[ENABLE_BIT];
          next_power_save = req_i.wdata[POWER_SAVE_BIT];
          next_alt_code = wr_code;
        end
        ADDR_VOLTAGE_LIMIT:
        begin
          if (!locked)
          begin
            next_range = req_i.wdata[7:RANGE_LSB];
            next_max_code = req_i.wdata[CODE_MSB:0];
          end
        end
        default:
          next_loaded = 1'b1;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // read path
  always_comb
  begin
    next_rdata = 8'h00;
    next_rvalid = req_i.rd;
    if (req_i.rd)
    begin
      case (req_i.addr)
        ADDR_OPERATING_POINT:
          next_rdata = {1'b0, alt_select, op_code};
        ADDR_ALT_VOLTAGE:
          next_rdata = {enable, power_save, alt_code};
        ADDR_VOLTAGE_LIMIT:
          next_rdata = {range, max_code};
        default:
          next_rdata = 8'h00;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // converter controls; forced-off gates enable, the field is kept
  always_comb
  begin
    next_ctrl.enable = enable && !forced_off_i;
    next_ctrl.power_save = power_save;
    next_ctrl.alt_select = alt_select;
    next_ctrl.code = active_code;
    next_ctrl.range = range;
    next_locked = locked;
  end

  //////////////////////////////////////////////////////////////////////////
  // register fields; reset holds them until the default load after release
  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      enable <= 1'b0;
      power_save <= POWER_SAVE_RESET;
      alt_select <= ALT_SELECT_RESET;
      op_code <= CODE_ZERO;
      alt_code <= CODE_ZERO;
      range <= 2'h0;
      max_code <= CODE_ALL_ONES;
      loaded <= 1'b0;
    end
    else
    begin
      enable <= next_enable;
      power_save <= next_power_save;
      alt_select <= next_alt_select;
      op_code <= next_op_code;
      alt_code <= next_alt_code;
      range <= next_range;
      max_code <= next_max_code;
      loaded <= next_loaded;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // read outputs
  // data returns to zero between reads so a stale byte never looks fresh
  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      rdata_o <= 8'h00;
      rvalid_o <= 1'b0;
    end
    else
    begin
      rdata_o <= next_rdata;
      rvalid_o <= next_rvalid;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // control outputs
  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      ctrl_o <= '0;
      limit_locked_o <= 1'b0;
    end
    else
    begin
      ctrl_o <= next_ctrl;
      limit_locked_o <= next_locked;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // voltage translation of the active code
  buck4_code_to_uv u_code_to_uv (
    .mclk_i(mclk_i),
    .rst_n_i(rst_n_i),
    .range_i(range_t'(range)),
    .code_i(active_code),
    .uv_o(target_uv_o)
  );

endmodule : buck4_voltage_regs
`default_nettype wire

// >>> buck4_pkg.sv
// shared constants and types for the buck4 register bank
package buck4_pkg;

  localparam logic [7:0] ADDR_OPERATING_POINT = 8'h0d;
  localparam logic [7:0] ADDR_ALT_VOLTAGE = 8'h0e;
  localparam logic [7:0] ADDR_VOLTAGE_LIMIT = 8'h0f;

  localparam int ENABLE_BIT = 7;
  localparam int POWER_SAVE_BIT = 6;
  localparam int ALT_SELECT_BIT = 6;
  localparam int CODE_MSB = 5;
  localparam int RANGE_LSB = 6;

  localparam logic [5:0] CODE_ALL_ONES = 6'h3f;
  localparam logic [5:0] CODE_ZERO = 6'h00;
  localparam logic POWER_SAVE_RESET = 1'b0;
  localparam logic ALT_SELECT_RESET = 1'b0;

  // output voltage in microvolts, per range: base and step
  localparam int RANGE0_BASE_UV = 500000;
  localparam int RANGE1_BASE_UV = 700000;
  localparam int RANGE2_BASE_UV = 500000;
  localparam int RANGE3_BASE_UV = 500000;
  localparam int RANGE0_STEP_UV = 12500;
  localparam int RANGE1_STEP_UV = 12500;
  localparam int RANGE2_STEP_UV = 25000;
  localparam int RANGE3_STEP_UV = 50000;
  localparam int RANGE3_TOP_UV = 3800000;

  typedef enum logic [1:0] {
    RANGE_FINE_LOW = 2'b00,
    RANGE_FINE_HIGH = 2'b01,
    RANGE_MEDIUM = 2'b10,
    RANGE_WIDE = 2'b11
  } range_t;

  // factory defaults presented by the one-time-programmable store
  typedef struct packed {
    logic enable;
    logic [5:0] op_code;
    logic [5:0] alt_code;
    logic [1:0] range;
    logic [5:0] max_code;
  } otp_defaults_t;

  // register access strobe from the serial host interface
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_t;

  typedef struct packed {
    logic enable;
    logic power_save;
    logic alt_select;
    logic [5:0] code;
    logic [1:0] range;
  } converter_ctrl_t;

endpackage : buck4_pkg

// >>> buck4_code_to_uv.sv
// registered voltage-code to microvolt translation for buck4
`timescale 1ns/1ps
`default_nettype none
module buck4_code_to_uv (
  input wire logic mclk_i,               // system clock
  input wire logic rst_n_i,              // async reset, active low
  input wire buck4_pkg::range_t range_i, // output range selector
  input wire logic [5:0] code_i,         // voltage code
  output logic [21:0] uv_o               // target voltage in microvolts
);
  import buck4_pkg::*;

  logic [21:0] next_uv;

  always_comb
  begin
    next_uv = 22'h00_0000;
    case (range_i)
      RANGE_FINE_LOW:
        next_uv = 22'(RANGE0_BASE_UV + RANGE0_STEP_UV * int'(code_i));
      RANGE_FINE_HIGH:
        next_uv = 22'(RANGE1_BASE_UV + RANGE1_STEP_UV * int'(code_i));
      RANGE_MEDIUM:
        next_uv = 22'(RANGE2_BASE_UV + RANGE2_STEP_UV * int'(code_i));
      RANGE_WIDE:
      begin
        if (code_i == CODE_ALL_ONES)
          next_uv = 22'(RANGE3_TOP_UV);
        else
          next_uv = 22'(RANGE3_BASE_UV + RANGE3_STEP_UV * int'(code_i));
      end
      default:
        next_uv = 22'h00_0000;
    endcase
  end

  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      uv_o <= 22'h00_0000;
    else
      uv_o <= next_uv;
  end

endmodule : buck4_code_to_uv
`default_nettype wire

// >>> host_model.sv
// host processor model issuing register accesses
`timescale 1ns/1ps
`default_nettype none
module host_model (
  input wire logic mclk_i, // clock
  input wire logic rvalid_i, // read valid
  input wire logic [7:0] rdata_i, // read data
  output buck4_pkg::reg_req_t req_o // register access
);
  import buck4_pkg::*;
  initial req_o = '0;
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    if (a == ADDR_OPERATING_POINT) v[7] = 1'b0;
    @(negedge mclk_i);
    req_o = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: v};
    @(negedge mclk_i);
    req_o = '0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(negedge mclk_i);
    req_o = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(negedge mclk_i);
    req_o = '0;
    v = rvalid_i ? rdata_i : 8'hxx;
  endtask : rd
endmodule : host_model
`default_nettype wire

// >>> buck4_chk_sva.sv
// assertion checker for the buck4 register bank
`timescale 1ns/1ps
`default_nettype none
module buck4_chk (
  input wire logic mclk_i, // clock
  input wire logic rst_n_i, // reset
  input wire logic otp_reload_i, // reload
  input wire buck4_pkg::otp_defaults_t otp_i, // defaults
  input wire buck4_pkg::reg_req_t req_i, // access
  input wire logic forced_off_i, // forced off
  input wire logic [7:0] rdata_o, // read data
  input wire logic rvalid_o, // read valid
  input wire buck4_pkg::converter_ctrl_t ctrl_o, // controls
  input wire logic limit_locked_o, // locked
  input wire logic [21:0] target_uv_o // target
);
  import buck4_pkg::*;
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);
  logic w_alt;
  assign w_alt = req_i.wr && req_i.addr == ADDR_ALT_VOLTAGE && !otp_reload_i;
  ////////////////////////////////////////////////////////////////////////////
  property p_rvalid; req_i.rd && !otp_reload_i |=> rvalid_o; endproperty
  a_rvalid: assert property (p_rvalid) else $error("no rvalid");
  property p_idle; !req_i.rd |=> !rvalid_o && rdata_o == 8'h00; endproperty
  a_idle: assert property (p_idle) else $error("idle read out");
  property p_unmap; req_i.rd && req_i.addr > 8'h0f |=> rdata_o == 8'h00;
  endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped data");
  property p_rsvd; req_i.rd && req_i.addr == 8'h0d |=> !rdata_o[7]; endproperty
  a_rsvd: assert property (p_rsvd) else $error("bit 7 set");
  property p_off; forced_off_i [*3] |-> !ctrl_o.enable; endproperty
  a_off: assert property (p_off) else $error("on while off");
  property p_lock; (limit_locked_o && !otp_reload_i) [*2] |=> limit_locked_o;
  endproperty
  a_lock: assert property (p_lock) else $error("lock lost");
  property p_ps; w_alt |-> ##2 ctrl_o.power_save == $past(req_i.wdata[6], 2);
  endproperty
  a_ps: assert property (p_ps) else $error("power save");
  property p_en; (w_alt && !forced_off_i) ##1 !forced_off_i [*2] |->
    ctrl_o.enable == $past(req_i.wdata[7], 2); endproperty
  a_en: assert property (p_en) else $error("enable");
endmodule : buck4_chk
bind buck4_voltage_regs buck4_chk u_chk (.mclk_i(mclk_i), .rst_n_i(rst_n_i),
  .otp_reload_i(otp_reload_i), .otp_i(otp_i), .req_i(req_i),
  .forced_off_i(forced_off_i), .rdata_o(rdata_o), .rvalid_o(rvalid_o),
  .ctrl_o(ctrl_o), .limit_locked_o(limit_locked_o), .target_uv_o(target_uv_o));
`default_nettype wire

// >>> testbench.sv
// self-checking bench for the buck4 register bank
`timescale 1ns/1ps
`default_nettype none
`define CHK(n,e,g) begin checked++; if ((g) !== (e)) begin failures++; \
  $display("CHECK FAILED %s exp %h got %h", n, e, g); end end
module testbench;
  import buck4_pkg::*;
  logic mclk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic otp_reload_i = 1'b0;
  logic forced_off_i = 1'b0;
  otp_defaults_t otp_i = '0;
  reg_req_t req_i;
  logic [7:0] rdata_o;
  logic rvalid_o;
  converter_ctrl_t ctrl_o;
  logic limit_locked_o;
  logic [21:0] target_uv_o;
  int failures = 0;
  int checked = 0;
  logic [7:0] d;
  logic [5:0] c;
  always #2 mclk_i = ~mclk_i;
  host_model host (.mclk_i(mclk_i), .rvalid_i(rvalid_o), .rdata_i(rdata_o),
    .req_o(req_i));
  buck4_voltage_regs dut (.mclk_i(mclk_i), .rst_n_i(rst_n_i),
    .otp_reload_i(otp_reload_i), .otp_i(otp_i), .req_i(req_i),
    .forced_off_i(forced_off_i), .rdata_o(rdata_o), .rvalid_o(rvalid_o),
    .ctrl_o(ctrl_o), .limit_locked_o(limit_locked_o),
    .target_uv_o(target_uv_o));
  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [21:0] uv(logic [1:0] r, logic [5:0] k);
    if (r == 2'b11 && k == 6'h3f) return 22'd3800000;
    return (r == 2'b01 ? 22'd700000 : 22'd500000) + k * (r == 2'b11 ?
      22'd50000 : r[1] ? 22'd25000 : 22'd12500);
  endfunction : uv
  task automatic tick(int n);
    repeat (n) @(negedge mclk_i);
  endtask : tick
  task automatic conclude;
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : conclude
  initial
  begin
    repeat (20000) @(posedge mclk_i);
    failures++;
    conclude();
  end
  initial
  begin
    void'($urandom(16));
    otp_i = otp_defaults_t'(21'($urandom));
    otp_i.max_code = 6'h3f;
    tick(12);
    rst_n_i = 1'b1;
    tick(3);
    host.rd(ADDR_ALT_VOLTAGE, d);
    `CHK("alt", {otp_i.enable, 1'b0, otp_i.alt_code}, d)
    host.rd(ADDR_VOLTAGE_LIMIT, d);
    `CHK("limit", {otp_i.range, 6'h3f}, d)
    host.wr(ADDR_OPERATING_POINT, 8'hc0);
    for (int r = 0; r < 4; r++)
      for (int k = 0; k < 2; k++)
      begin
        c = k ? 6'h3f : 6'($urandom);
        host.wr(ADDR_VOLTAGE_LIMIT, {2'(r), 6'h3f});
        host.wr(ADDR_ALT_VOLTAGE, {2'b10, c});
        tick(4);
        `CHK("uv", uv(2'(r), c), target_uv_o)
      end
    host.wr(ADDR_VOLTAGE_LIMIT, 8'h60);
    host.wr(ADDR_ALT_VOLTAGE, 8'hff);
    host.wr(ADDR_OPERATING_POINT, 8'hff);
    host.wr(ADDR_VOLTAGE_LIMIT, 8'h3f);
    host.rd(ADDR_ALT_VOLTAGE, d);
    `CHK("clamp", 8'he0, d)
    host.rd(ADDR_OPERATING_POINT, d);
    `CHK("op", 8'h60, d)
    host.rd(ADDR_VOLTAGE_LIMIT, d);
    `CHK("held", 8'h60, d)
    `CHK("locked", 1'b1, limit_locked_o)
    `CHK("uv", uv(2'b01, 6'h20), target_uv_o)
    `CHK("on", 1'b1, ctrl_o.enable)
    `CHK("ctrl", {1'b1, 1'b1, 1'b1, 6'h20, 2'b01}, ctrl_o)
    forced_off_i = 1'b1;
    tick(3);
    `CHK("off", 1'b0, ctrl_o.enable)
    forced_off_i = 1'b0;
    host.rd(8'h10, d);
    `CHK("unmapped", 8'h00, d)
    otp_reload_i = 1'b1;
    tick(1);
    otp_reload_i = 1'b0;
    tick(3);
    `CHK("unlocked", 1'b0, limit_locked_o)
    host.rd(ADDR_VOLTAGE_LIMIT, d);
    `CHK("reload", {otp_i.range, 6'h3f}, d)
    host.wr(ADDR_ALT_VOLTAGE, 8'h40);
    rst_n_i = 1'b0;
    otp_i.max_code = 6'h15;
    tick(2);
    rst_n_i = 1'b1;
    tick(3);
    host.rd(ADDR_ALT_VOLTAGE, d);
    `CHK("por", {otp_i.enable, 1'b0, otp_i.alt_code}, d)
    `CHK("otp lock", 1'b1, limit_locked_o)
    host.wr(ADDR_VOLTAGE_LIMIT, 8'h3f);
    host.rd(ADDR_VOLTAGE_LIMIT, d);
    `CHK("otp held", {otp_i.range, 6'h15}, d)
    host.wr(ADDR_ALT_VOLTAGE, 8'h3f);
    host.rd(ADDR_ALT_VOLTAGE, d);
    `CHK("otp clamp", 8'h15, d)
    conclude();
  end
endmodule : testbench
`default_nettype wire
